// ==== hw/spi_sel_pkg.sv ====
package spi_sel_pkg;
  localparam int         WORD_BITS     = 8;
  localparam logic [1:0] SEL_3WIRE     = 2'h0;
  localparam logic [1:0] SEL_4W_IN     = 2'h1;
  localparam int         SEL_OUT_BIT   = 1;
  localparam int         SEL_LVL_BIT   = 0;
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         SCK_HALF_NS   = 40;
  localparam int         SCK_HALF_CYC  =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [2:0] CNT_RESET     = 3'h0;
  localparam logic [2:0] CNT_LAST      = 3'h7;

  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_LOW  = 3'b010,
    M_HIGH = 3'b100
  } mstate_t;

  typedef struct packed {
    logic       enable;
    logic       master;
    logic [1:0] select_mode_field;
  } cfg_t;
endpackage

// ==== hw/serial_peripheral_unit.sv ====
`timescale 1ns/100ps
// Behaviour
// - MOSI is driven as an output when master and is an input when slave.
// - Data on MOSI and MISO moves most significant bit first.
// - As master the shift register MSB is presented on MOSI in all modes.
// - MISO is an input when master and an output when slave.
// - MISO floats when disabled or when an unselected 4-wire slave.
// - A 3-wire slave drives MISO from its shift register MSB, never gated.
// - The master makes SCK; the unit drives SCK as master, takes it as slave.
// - A 4-wire slave ignores SCK entirely while the select input is high.
// - Select mode 00 is 3-wire, select unused, slave always selected.
// - Select mode 01 is 4-wire with the select line as an input.
// - In mode 01 a falling select input disables the master function.
// - Select mode 1x drives the select line out at the mode's low bit.
// - The select line is routed to a pin in every mode except 3-wire.
module serial_peripheral_unit #(
  parameter int WIDTH    = spi_sel_pkg::WORD_BITS,
  parameter int HALF_CYC = spi_sel_pkg::SCK_HALF_CYC
) (
  input  wire logic               SYS_CLK_I,
  input  wire logic               RESETN_I,
  input  wire spi_sel_pkg::cfg_t  CFG_I,
  input  wire logic               FAULT_CLR_I,
  input  wire logic               START_I,
  input  wire logic [WIDTH-1:0]   TX_DATA_I,
  output logic      [WIDTH-1:0]   RX_DATA_O,
  output logic                    RX_VALID_O,
  output logic                    BUSY_O,
  output logic                    MODE_FAULT_O,
  output logic                    SSEL_ROUTED_O,
  input  wire logic               SCK_I,
  output logic                    SCK_O,
  output logic                    SCK_OE_O,
  input  wire logic               MOSI_I,
  output logic                    MOSI_O,
  output logic                    MOSI_OE_O,
  input  wire logic               MISO_I,
  output logic                    MISO_O,
  output logic                    MISO_OE_O,
  input  wire logic               SSEL_I,
  output logic                    SSEL_O,
  output logic                    SSEL_OE_O
);
  import spi_sel_pkg::*;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  function automatic logic sel_is(input logic [1:0] f,
                                  input logic [1:0] v);
    sel_is = (f == v);
  endfunction

  mstate_t            state_reg;
  logic [7:0]         div_reg;
  logic [2:0]         bit_reg;
  logic [WIDTH-1:0]   m_sr_reg;
  logic               sck_reg;
  logic               busy_reg;
  logic               mosi_reg;
  logic               fault_reg;
  logic               mosi_oe_reg;
  logic               sck_oe_reg;
  logic               miso_oe_reg;
  logic               ssel_o_reg;
  logic               ssel_oe_reg;
  logic               routed_reg;
  logic               slave_role_reg;
  logic [WIDTH-1:0]   rx_reg;
  logic               rx_valid_reg;
  logic [WIDTH-1:0]   slv_tx_reg;
  logic               nss_s1;
  logic               nss_s2;
  logic               nss_s3;
  logic               miso_s1;
  logic               miso_s2;
  logic               done_s1;
  logic               done_s2;
  logic               done_s3;
  logic               mode01;
  logic               master_eff;
  logic               link_rst_n;
  // Link (SCK) domain
  logic [2:0]         out_cnt;
  logic [WIDTH-1:0]   s_tx_sh;
  logic               s_miso_reg;
  logic [2:0]         in_cnt;
  logic [WIDTH-1:0]   s_in_sh;
  logic [WIDTH-1:0]   s_rx_reg;
  logic               done_tgl;

  assign mode01     = sel_is(CFG_I.select_mode_field, SEL_4W_IN);
  assign master_eff = CFG_I.enable & CFG_I.master & ~fault_reg;

  // Pin synchronisers
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      nss_s1  <= 1'b1;
      nss_s2  <= 1'b1;
      nss_s3  <= 1'b1;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      nss_s1  <= SSEL_I;
      nss_s2  <= nss_s1;
      nss_s3  <= nss_s2;
      miso_s1 <= MISO_I;
      miso_s2 <= miso_s1;
    end
  end

  // Mode fault: a falling select line takes the master role away
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      fault_reg <= 1'b0;
    end else if (mode01 && CFG_I.enable && CFG_I.master &&
                 nss_s3 && !nss_s2) begin
      fault_reg <= 1'b1;
    end else if (FAULT_CLR_I) begin
      fault_reg <= 1'b0;
    end
  end

  // Pin direction and select line
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mosi_oe_reg    <= 1'b0;
      sck_oe_reg     <= 1'b0;
      miso_oe_reg    <= 1'b0;
      ssel_o_reg     <= 1'b1;
      ssel_oe_reg    <= 1'b0;
      routed_reg     <= 1'b0;
      slave_role_reg <= 1'b0;
    end else begin
      mosi_oe_reg    <= master_eff;
      sck_oe_reg     <= master_eff;
      miso_oe_reg    <= CFG_I.enable & ~master_eff &
                        ~(mode01 & nss_s2);
      ssel_o_reg     <= CFG_I.select_mode_field[SEL_LVL_BIT];
      ssel_oe_reg    <= CFG_I.enable &
                        CFG_I.select_mode_field[SEL_OUT_BIT];
      routed_reg     <= !sel_is(CFG_I.select_mode_field,
                                SEL_3WIRE);
      slave_role_reg <= CFG_I.enable & ~master_eff;
    end
  end

  // Master transfer engine, SCK idles low, data launched on rising edge
  // Busy is a register of its own so that the pin leaves a flop directly
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg <= M_IDLE;
      div_reg   <= 8'h00;
      bit_reg   <= CNT_RESET;
      m_sr_reg  <= BYTE_RESET;
      sck_reg   <= 1'b0;
      mosi_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else if (!master_eff) begin
      state_reg <= M_IDLE;
      sck_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      case (state_reg)
        M_IDLE: begin
          if (START_I) begin
            m_sr_reg  <= TX_DATA_I;
            bit_reg   <= CNT_RESET;
            div_reg   <= 8'h00;
            state_reg <= M_LOW;
            busy_reg  <= 1'b1;
          end
        end
        M_LOW: begin
          if (div_reg == HALF_LAST) begin
            div_reg   <= 8'h00;
            sck_reg   <= 1'b1;
            mosi_reg  <= m_sr_reg[WIDTH-1];
            state_reg <= M_HIGH;
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        M_HIGH: begin
          if (div_reg == HALF_LAST) begin
            div_reg  <= 8'h00;
            sck_reg  <= 1'b0;
            m_sr_reg <= {m_sr_reg[WIDTH-2:0], miso_s2};
            bit_reg  <= bit_reg + 3'h1;
            if (bit_reg == CNT_LAST) begin
              state_reg <= M_IDLE;
              busy_reg  <= 1'b0;
            end else begin
              state_reg <= M_LOW;
            end
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= M_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // Byte the slave will send on its next frame
  // Read by the link side as is, so it must stay steady inside a frame
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      slv_tx_reg <= BYTE_RESET;
    end else if (START_I && slave_role_reg) begin
      slv_tx_reg <= TX_DATA_I;
    end
  end

  // Received byte hand-off to the system side
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      done_s1      <= 1'b0;
      done_s2      <= 1'b0;
      done_s3      <= 1'b0;
      rx_reg       <= BYTE_RESET;
      rx_valid_reg <= 1'b0;
    end else begin
      done_s1      <= done_tgl;
      done_s2      <= done_s1;
      done_s3      <= done_s2;
      rx_valid_reg <= 1'b0;
      if (state_reg == M_HIGH && div_reg == HALF_LAST &&
          bit_reg == CNT_LAST && master_eff) begin
        rx_reg       <= {m_sr_reg[WIDTH-2:0], miso_s2};
        rx_valid_reg <= 1'b1;
      end else if (done_s2 != done_s3) begin
        rx_reg       <= s_rx_reg;
        rx_valid_reg <= 1'b1;
      end
    end
  end

  // Slave logic is held in reset while not an active selected slave
  // Select is taken after its synchroniser so a pin glitch cannot reset
  assign link_rst_n = RESETN_I & slave_role_reg &
                      ~(mode01 & nss_s2);

  // Slave launch on rising SCK, reload every byte
  always_ff @(posedge SCK_I or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_cnt    <= CNT_RESET;
      s_tx_sh    <= BYTE_RESET;
      s_miso_reg <= 1'b0;
    end else begin
      out_cnt <= out_cnt + 3'h1;
      if (out_cnt == CNT_RESET) begin
        s_miso_reg <= slv_tx_reg[WIDTH-1];
        s_tx_sh    <= {slv_tx_reg[WIDTH-2:0], 1'b0};
      end else begin
        s_miso_reg <= s_tx_sh[WIDTH-1];
        s_tx_sh    <= {s_tx_sh[WIDTH-2:0], 1'b0};
      end
    end
  end

  // Slave capture on falling SCK
  always_ff @(negedge SCK_I or negedge link_rst_n) begin
    if (!link_rst_n) begin
      in_cnt  <= CNT_RESET;
      s_in_sh <= BYTE_RESET;
    end else begin
      in_cnt  <= in_cnt + 3'h1;
      s_in_sh <= {s_in_sh[WIDTH-2:0], MOSI_I};
    end
  end

  // Completed byte and toggle survive the frame reset
  always_ff @(negedge SCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_rx_reg <= BYTE_RESET;
      done_tgl <= 1'b0;
    end else if (link_rst_n && in_cnt == CNT_LAST) begin
      s_rx_reg <= {s_in_sh[WIDTH-2:0], MOSI_I};
      done_tgl <= ~done_tgl;
    end
  end

  assign RX_DATA_O     = rx_reg;
  assign RX_VALID_O    = rx_valid_reg;
  assign BUSY_O        = busy_reg;
  assign MODE_FAULT_O  = fault_reg;
  assign SSEL_ROUTED_O = routed_reg;
  assign SCK_O         = sck_reg;
  assign SCK_OE_O      = sck_oe_reg;
  assign MOSI_O        = mosi_reg;
  assign MOSI_OE_O     = mosi_oe_reg;
  assign MISO_O        = s_miso_reg;
  assign MISO_OE_O     = miso_oe_reg;
  assign SSEL_O        = ssel_o_reg;
  assign SSEL_OE_O     = ssel_oe_reg;
endmodule // serial_peripheral_unit

// ==== testbench/spi_sel_assertions.sv ====
`timescale 1ns/100ps
module spi_sel_assertions #(
  parameter int WIDTH    = 8,
  parameter int HALF_CYC = 5
) (
  input wire logic              SYS_CLK_I,
  input wire logic              RESETN_I,
  input wire spi_sel_pkg::cfg_t CFG_I,
  input wire logic              START_I,
  input wire logic [WIDTH-1:0]  TX_DATA_I,
  input wire logic              RX_VALID_O,
  input wire logic              BUSY_O,
  input wire logic              MODE_FAULT_O,
  input wire logic              SSEL_ROUTED_O,
  input wire logic              SCK_O,
  input wire logic              SCK_OE_O,
  input wire logic              MOSI_O,
  input wire logic              MOSI_OE_O,
  input wire logic              MISO_OE_O,
  input wire logic              SSEL_I
);
  import spi_sel_pkg::*;
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  // Cycle figures below hold for the default HALF_CYC of 5
  sequence s_start;
    START_I && !BUSY_O && CFG_I.enable && CFG_I.master && !MODE_FAULT_O;
  endsequence
  sequence s_half;
    s_start ##1 BUSY_O [*5];
  endsequence
  a_slave_quiet: assert property (
    $stable(CFG_I) && !CFG_I.master |=> !MOSI_OE_O && !SCK_OE_O)
    else $error("master pins driven as slave");
  a_miso_float: assert property (
    $stable(CFG_I) && !(CFG_I.enable && (!CFG_I.master || MODE_FAULT_O))
      |=> !MISO_OE_O)
    else $error("miso driven when not slave");
  a_wire3_drive: assert property (
    $stable(CFG_I) && CFG_I.enable && !CFG_I.master
      && CFG_I.select_mode_field == SEL_3WIRE |=> MISO_OE_O)
    else $error("3-wire slave not driving miso");
  a_sel_routed: assert property (
    $stable(CFG_I) |=> SSEL_ROUTED_O == (|$past(CFG_I.select_mode_field)))
    else $error("select routing wrong");
  a_first_bit: assert property (
    s_half |=> SCK_O && MOSI_O == $past(TX_DATA_I[WIDTH-1], 6))
    else $error("first bit not msb");
  a_byte_done: assert property (
    s_start |=> (BUSY_O throughout ##79 1'b1) ##1 (RX_VALID_O && !BUSY_O))
    else $error("byte end out of time");
  a_fault_set: assert property (
    $stable(CFG_I) && CFG_I.enable && CFG_I.master && $fell(SSEL_I)
      && CFG_I.select_mode_field == SEL_4W_IN |-> ##[1:4] MODE_FAULT_O)
    else $error("fault not raised");
  a_sck_ignored: assert property (
    (CFG_I.enable && !CFG_I.master && SSEL_I
      && CFG_I.select_mode_field == SEL_4W_IN) [*8] |-> !RX_VALID_O)
    else $error("byte taken while deselected");
endmodule // spi_sel_assertions

bind serial_peripheral_unit spi_sel_assertions #(
  .WIDTH(WIDTH), .HALF_CYC(HALF_CYC)
) chk_i (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .CFG_I(CFG_I),
  .START_I(START_I), .TX_DATA_I(TX_DATA_I), .RX_VALID_O(RX_VALID_O),
  .BUSY_O(BUSY_O), .MODE_FAULT_O(MODE_FAULT_O),
  .SSEL_ROUTED_O(SSEL_ROUTED_O), .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O),
  .MOSI_O(MOSI_O), .MOSI_OE_O(MOSI_OE_O), .MISO_OE_O(MISO_OE_O),
  .SSEL_I(SSEL_I)
);

// ==== testbench/far_end.sv ====
`timescale 1ns/100ps
// Sole slave on the bus when ours is master, master when ours is slave
module far_end (
  input  wire logic sck_m,
  input  wire logic mosi_m,
  output logic      miso_m,
  output logic      sck_s,
  output logic      mosi_s,
  input  wire logic miso_s
);
  logic [7:0] sh_reg;
  logic [7:0] got_reg;
  initial begin
    {miso_m, sck_s, mosi_s, sh_reg} = 11'h0;
  end
  always @(posedge sck_m) begin
    miso_m <= sh_reg[7];
    sh_reg <= {sh_reg[6:0], ~sh_reg[7]};
  end
  always @(negedge sck_m) begin
    got_reg <= {got_reg[6:0], mosi_m};
  end
  task automatic load(input logic [7:0] b);
    sh_reg = b;
  endtask
  // 15 ns link clock, low between frames
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      #3.75 mosi_s = b[i];
      #3.75 sck_s = 1'b1;
      #7.5 sck_s = 1'b0;
      r = {r[6:0], miso_s};
    end
    #3.75 mosi_s = ~mosi_s;
  endtask
endmodule // far_end

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
  import spi_sel_pkg::*;
  logic       clk, rst_n, fclr, start, ssel, rxv, busy, fault, routed;
  logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic       sck_s, mosi_s, miso_m;
  logic [7:0] txd, rxd, rx_last, got;
  cfg_t       cfg;
  int         miscompares = 0, num_checks = 0, rx_cnt = 0;
  serial_peripheral_unit uut (.SYS_CLK_I(clk), .RESETN_I(rst_n),
    .CFG_I(cfg), .FAULT_CLR_I(fclr), .START_I(start), .TX_DATA_I(txd),
    .RX_DATA_O(rxd), .RX_VALID_O(rxv), .BUSY_O(busy),
    .MODE_FAULT_O(fault), .SSEL_ROUTED_O(routed), .SCK_I(sck_s),
    .SCK_O(sck_o), .SCK_OE_O(sck_oe), .MOSI_I(mosi_s), .MOSI_O(mosi_o),
    .MOSI_OE_O(mosi_oe), .MISO_I(miso_m), .MISO_O(miso_o),
    .MISO_OE_O(miso_oe), .SSEL_I(ssel), .SSEL_O(ss_o), .SSEL_OE_O(ss_oe));
  far_end far (.sck_m(sck_o), .mosi_m(mosi_o), .miso_m(miso_m),
    .sck_s(sck_s), .mosi_s(mosi_s), .miso_s(miso_o));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rxv === 1'b1) begin
      rx_cnt++;
      rx_last = rxd;
    end
  end
  task automatic chk(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse_start();
    start = 1'b1;
    cyc(1);
    start = 1'b0;
  endtask
  task automatic wait_rx(input int n0);
    for (int i = 0; i < 200 && rx_cnt == n0; i++) @(negedge clk);
  endtask
  task automatic t_modes();
    for (int f = 0; f < 4; f++) begin
      cfg = '{1'b1, 1'b1, 2'(f)};
      cyc(2);
      chk("routed", routed, f != 0);
      chk("sel out", {ss_oe, ss_o & f[1]}, {f[1], f[1] & f[0]});
    end
    cfg.enable = 1'b0;
    cyc(2);
    chk("idle oe", {mosi_oe, sck_oe, miso_oe, ss_oe}, 8'h0);
  endtask
  task automatic t_master();
    logic [7:0] pat [2] = '{8'ha5, 8'h3c};
    cfg = '{1'b1, 1'b1, SEL_3WIRE};
    cyc(2);
    for (int i = 0; i < 2; i++) begin
      far.load(~pat[i]);
      txd = pat[i];
      pulse_start();
      wait_rx(rx_cnt);
      chk("master rx", rx_last, ~pat[i]);
      chk("far got", far.got_reg, pat[i]);
    end
  endtask
  task automatic t_slave();
    int n0;
    for (int m = 0; m < 3; m++) begin
      cfg = '{1'b1, 1'b0, 2'(m != 0)};
      ssel = (m != 1);
      txd = 8'hd1 ^ 8'(m);
      cyc(3);
      pulse_start();
      n0 = rx_cnt;
      chk("miso oe", miso_oe, m < 2);
      far.xfer(~txd, got);
      wait_rx(n0);
      chk("rx count", 8'(rx_cnt - n0), 8'(m < 2));
      if (m < 2) begin
        chk("slave rx", rx_last, ~txd);
        chk("slave tx", got, txd);
      end
    end
  endtask
  task automatic t_fault();
    cfg = '{1'b1, 1'b1, SEL_4W_IN};
    cyc(3);
    ssel = 1'b0;
    cyc(5);
    chk("fault", fault, 1'b1);
    pulse_start();
    cyc(2);
    chk("no start", busy, 1'b0);
    ssel = 1'b1;
    fclr = 1'b1;
    cyc(1);
    fclr = 1'b0;
    cyc(1);
    chk("fault clear", fault, 1'b0);
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {rst_n, fclr, start, ssel, txd, cfg} = 16'h1000;
    cyc(5);
    rst_n = 1'b1;
    t_modes();
    t_master();
    t_slave();
    t_fault();
    close_out();
  end
  initial begin
    #50000;
    miscompares++;
    close_out();
  end
endmodule // tb
